/* include/dcc_defs.vh */
// Register map, field positions and timing constants of the comparator control block
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// Bus address width and response codes
`define DCC_AW 10
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2

// Register indices, byte address is four times the index
`define DCC_IDX_COMPARATOR_ONE_CONTROL 8'hAC
`define DCC_IDX_COMPARATOR_TWO_CONTROL 8'hAD
`define DCC_IDX_IRQ_CTRL 8'hB0
`define DCC_IDX_STATUS 8'hB1
`define DCC_IDX_CLEAR 8'hB2
`define DCC_IDX_ENABLE 8'hB3
`define DCC_IDX_POWER 8'hB4

// Comparator control fields
`define DCC_B_FLAG 0
`define DCC_B_SYNC 1
`define DCC_B_PINOE 2
`define DCC_B_NEGSEL 3
`define DCC_B_POSSEL 4
`define DCC_B_ON 5

// Interrupt control fields
`define DCC_B_CMP_IRQ_EN 0
`define DCC_B_GLOBAL_IRQ_EN 1

// Status fields
`define DCC_B_ST_FLAG 0
`define DCC_B_ST_SYNC 2
`define DCC_B_ST_READY 4

// Power control field
`define DCC_B_PWR_OFF 5

// Reset values
`define DCC_RST_CTRL 1'b0
`define DCC_RST_MASK 2'h3

// Settling time after enable
`define DCC_SETTLE_NS 10000
`define DCC_CLK_MHZ 50
`define DCC_NS_PER_US 1000

`endif

/* src/dcc_top.v */
// Dual comparator control, flags, interrupt and AXI4-Lite register slave
//
// Behaviour
// RULE1 - Result is 1 when selected positive input exceeds selected negative, else 0
// RULE2 - Two identical 8-bit control registers at indices ACh and ADh
// RULE3 - Bit 0 change flag set on each synchronized result change, kept until cleared
// RULE4 - Bit 1 shows synchronized result, read-only
// RULE5 - Bit 2 with comparator on drives raw result onto the result pin
// RULE6 - Bit 3 picks negative input: 0 reference pin, 1 internal reference
// RULE7 - Bit 4 picks positive input: 0 pin A, 1 pin B
// RULE8 - Bit 5 turns comparator on; output unstable for 10 microseconds after
// RULE9 - Software keeps interrupt off 10 us after enable, clears flag first
// RULE10 - Shared interrupt when any flag set and both enables set; code also needs that flag's mask bit set in the enable register
// RULE11 - Disabled comparator forces synchronized result high, rising edge sets flag
// RULE12 - Software disables interrupt before disabling comparator, then clears flag
// RULE13 - Comparators run in idle and power-down; total power-down turns both off
// RULE14 - Enabled interrupt on result change wakes from idle or power-down
// RULE15 - Power control bit 5 with comparators off powers down comparator circuitry
// RULE16 - Interrupt routine clears the responsible change flag before returning
// RULE17 - Change seen against previous cycle; hardware set beats software clear
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "dcc_defs.vh"

module dcc_top #(
   parameter VW = 8
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // AXI4-Lite write address
   input wire [`DCC_AW-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // AXI4-Lite read address
   input wire [`DCC_AW-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // Sampled input levels, comparator 2 in the upper half of each positive input, references shared
   input wire [2*VW-1:0] pos_pin_a_i,
   input wire [2*VW-1:0] pos_pin_b_i,
   input wire [VW-1:0] ref_pin_i,
   input wire [VW-1:0] int_ref_i,
   // Power modes
   input wire idle_mode_i,
   input wire power_down_i,
   input wire total_power_down_i,
   // Result pins
   output reg [1:0] result_pin_o,
   output reg [1:0] result_pin_oe_o,
   // Interrupt, wake and power
   output reg irq_o,
   output reg wake_o,
   output reg cmp_power_down_o
);

   // Settling cycles, rounded up, cut to the counter width
   localparam [31:0] SETTLE_FULL = (`DCC_SETTLE_NS * `DCC_CLK_MHZ + `DCC_NS_PER_US - 1) /
      `DCC_NS_PER_US;
   localparam [15:0] SETTLE_CYC = SETTLE_FULL[15:0];

   // Write channel holding
   reg aw_held;
   reg w_held;
   reg [`DCC_AW-1:0] aw_addr;
   reg [7:0] w_byte;
   reg w_lane;
   wire wr_en = aw_held & w_held & ~s_axi_bvalid_o;
   wire [7:0] wr_idx = aw_addr[`DCC_AW-1:2];
   wire wr_al = (aw_addr[1:0] == 2'h0);
   wire wr_go = wr_en & wr_al & w_lane;
   wire [7:0] rd_idx = s_axi_araddr_i[`DCC_AW-1:2];
   wire rd_al = (s_axi_araddr_i[1:0] == 2'h0);

   // Software registers
   reg cmp_irq_en;
   reg global_irq_en;
   reg [1:0] irq_mask;
   reg pwr_off;

   // Per-comparator state
   wire [1:0] flag;
   wire [1:0] sres;
   wire [1:0] on;
   wire [1:0] ready;
   wire [15:0] ctrl_rd;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_cmp
         wire [7:0] my_idx = (g == 0) ? `DCC_IDX_COMPARATOR_ONE_CONTROL : `DCC_IDX_COMPARATOR_TWO_CONTROL;
         wire wr_me = wr_go & (wr_idx == my_idx);
         wire wr_clr = wr_go & (wr_idx == `DCC_IDX_CLEAR) & w_byte[g];
         reg c_on;
         reg c_possel;
         reg c_negsel;
         reg c_pinoe;
         reg c_flag;
         reg s1;
         reg s2;
         reg res;
         reg prev;
         reg [15:0] cnt;
         wire [VW-1:0] pos = c_possel ? pos_pin_b_i[g*VW +: VW] : pos_pin_a_i[g*VW +: VW]; // RULE7
         wire [VW-1:0] neg = c_negsel ? int_ref_i : ref_pin_i; // RULE6
         wire raw = (pos > neg); // RULE1
         wire change = (res != prev); // RULE17

         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               c_on <= `DCC_RST_CTRL;
               c_possel <= `DCC_RST_CTRL;
               c_negsel <= `DCC_RST_CTRL;
               c_pinoe <= `DCC_RST_CTRL;
            end else begin
               if (total_power_down_i) begin
                  c_on <= 1'b0; // RULE13
               end else if (wr_me) begin
                  c_on <= w_byte[`DCC_B_ON]; // RULE8
               end
               if (wr_me) begin // RULE2
                  c_possel <= w_byte[`DCC_B_POSSEL];
                  c_negsel <= w_byte[`DCC_B_NEGSEL];
                  c_pinoe <= w_byte[`DCC_B_PINOE];
               end
            end
         end

         // Synchronizer, forced high while off
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1 <= 1'b1;
               s2 <= 1'b1;
               res <= 1'b1;
               prev <= 1'b1;
            end else begin
               s1 <= raw;
               s2 <= s1;
               res <= c_on ? s2 : 1'b1; // RULE4 RULE11
               prev <= res;
            end
         end

         // Change flag, hardware set wins
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               c_flag <= 1'b0;
            end else if (change) begin
               c_flag <= 1'b1; // RULE3 RULE17
            end else if ((wr_me & ~w_byte[`DCC_B_FLAG]) | wr_clr) begin
               c_flag <= 1'b0; // RULE3
            end
         end

         // Settle counter after enable
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               cnt <= 16'h0000;
            end else if (!c_on) begin
               cnt <= 16'h0000;
            end else if (cnt != SETTLE_CYC) begin
               cnt <= cnt + 16'h0001; // RULE8
            end
         end

         // Raw result to pin, one flop only
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               result_pin_o[g] <= 1'b0;
               result_pin_oe_o[g] <= 1'b0;
            end else begin
               result_pin_o[g] <= raw; // RULE5
               result_pin_oe_o[g] <= c_on & c_pinoe; // RULE5
            end
         end

         assign flag[g] = c_flag;
         assign sres[g] = res;
         assign on[g] = c_on;
         assign ready[g] = c_on & (cnt == SETTLE_CYC);
         assign ctrl_rd[g*8 +: 8] = {2'h0, c_on, c_possel, c_negsel, c_pinoe, res, c_flag};
      end
   endgenerate

   // Write address and data acceptance
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`DCC_AW{1'b0}};
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `DCC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_held <= 1'b1;
            w_byte <= s_axi_wdata_i[7:0];
            w_lane <= s_axi_wstrb_i[0];
         end
         if (wr_en) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (wr_al && (wr_idx == `DCC_IDX_COMPARATOR_ONE_CONTROL || wr_idx == `DCC_IDX_COMPARATOR_TWO_CONTROL ||
               wr_idx == `DCC_IDX_IRQ_CTRL || wr_idx == `DCC_IDX_STATUS ||
               wr_idx == `DCC_IDX_CLEAR || wr_idx == `DCC_IDX_ENABLE ||
               wr_idx == `DCC_IDX_POWER)) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // Shared software registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_irq_en <= 1'b0;
         global_irq_en <= 1'b0;
         irq_mask <= `DCC_RST_MASK;
         pwr_off <= 1'b0;
      end else if (wr_go) begin
         if (wr_idx == `DCC_IDX_IRQ_CTRL) begin
            cmp_irq_en <= w_byte[`DCC_B_CMP_IRQ_EN];
            global_irq_en <= w_byte[`DCC_B_GLOBAL_IRQ_EN];
         end
         if (wr_idx == `DCC_IDX_ENABLE) begin
            irq_mask <= w_byte[1:0];
         end
         if (wr_idx == `DCC_IDX_POWER) begin
            pwr_off <= w_byte[`DCC_B_PWR_OFF];
         end
      end
   end

   // Read data mux
   reg [7:0] rd_byte;
   reg rd_ok;
   always @* begin
      rd_byte = 8'h00;
      rd_ok = rd_al;
      case (rd_idx)
         `DCC_IDX_COMPARATOR_ONE_CONTROL: rd_byte = ctrl_rd[7:0];
         `DCC_IDX_COMPARATOR_TWO_CONTROL: rd_byte = ctrl_rd[15:8];
         `DCC_IDX_IRQ_CTRL: rd_byte = {6'h00, global_irq_en, cmp_irq_en};
         `DCC_IDX_STATUS: rd_byte = {2'h0, ready, sres, flag};
         `DCC_IDX_CLEAR: rd_byte = 8'h00;
         `DCC_IDX_ENABLE: rd_byte = {6'h00, irq_mask};
         `DCC_IDX_POWER: rd_byte = {2'h0, pwr_off, 5'h00};
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= `DCC_RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
         s_axi_rresp_o <= rd_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // Interrupt, wake and power down
   wire irq_req = (|(flag & irq_mask)) & cmp_irq_en & global_irq_en;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         wake_o <= 1'b0;
         cmp_power_down_o <= 1'b0;
      end else begin
         irq_o <= irq_req; // RULE10
         wake_o <= irq_req & (idle_mode_i | power_down_i) & ~total_power_down_i; // RULE14
         cmp_power_down_o <= (pwr_off & ~(|on)) | total_power_down_i; // RULE15
      end
   end

endmodule // dcc_top

/* bench/dcc_level_model.sv */
// Analog input level model for the comparator control block
module dcc_level_model (
   // Level pattern, one bit per positive input
   input wire logic [3:0] pat_i,
   // Levels to the comparator inputs
   output logic [15:0] pos_a_o,
   output logic [15:0] pos_b_o,
   output logic [7:0] ref_o,
   output logic [7:0] iref_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // High level equals the internal reference
   assign pos_a_o = {(pat_i[1] ? 8'hC0 : 8'h40), (pat_i[0] ? 8'hC0 : 8'h40)};
   assign pos_b_o = {(pat_i[3] ? 8'hC0 : 8'h40), (pat_i[2] ? 8'hC0 : 8'h40)};
   assign ref_o = 8'h80;
   assign iref_o = 8'hC0;
endmodule // dcc_level_model

/* bench/dcc_checker.sv */
// Assertion checker for the comparator control block
module dcc_checker (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Bus handshakes
   input wire s_axi_awready_o,
   input wire s_axi_wready_o,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire s_axi_arready_o,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [31:0] s_axi_rdata_o,
   // Power, pins and interrupt
   input wire idle_mode_i,
   input wire power_down_i,
   input wire total_power_down_i,
   input wire [1:0] result_pin_oe_o,
   input wire irq_o,
   input wire wake_o,
   input wire cmp_power_down_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_bhs; s_axi_bvalid_o && s_axi_bready_i; endsequence
   sequence s_rhs; s_axi_rvalid_o && s_axi_rready_i; endsequence
   sequence s_tpd; total_power_down_i [*2]; endsequence
   a_b_rise: assert property (
      $rose(s_axi_bvalid_o) |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("Write answer with readies high");
   a_r_rise: assert property (
      $rose(s_axi_rvalid_o) |-> !s_axi_arready_o)
      else $error("Read answer with ready high");
   a_b_release: assert property (
      s_bhs |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
      else $error("Write answer not closed");
   a_r_release: assert property (
      s_rhs |=> !s_axi_rvalid_o && s_axi_arready_o)
      else $error("Read answer not closed");
   a_rdata_upper: assert property (
      s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("Upper read data not zero");
   a_wake_gate: assert property (
      wake_o |-> irq_o && $past(idle_mode_i || power_down_i) && !$past(total_power_down_i))
      else $error("Wake without cause");
   a_pwr_total: assert property (
      total_power_down_i |=> cmp_power_down_o)
      else $error("Circuitry not powered down");
   a_oe_total_off: assert property (
      s_tpd |=> result_pin_oe_o == 2'b00)
      else $error("Pin driven in total power down");
endmodule // dcc_checker
bind dcc_top dcc_checker i_chk (.*);

/* bench/dual_comparator_control_test.sv */
// Self-checking bench of the comparator control block
`include "dcc_defs.vh"
module dual_comparator_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] idx;
      logic [3:0] pat;
      logic [7:0] ctl;
      logic [7:0] exp;
   } dcc_row_t;
   logic clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
   logic s_axi_rready_i, idle_mode_i, power_down_i, total_power_down_i;
   logic [9:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, rv;
   logic [3:0] s_axi_wstrb_i, pat;
   logic [1:0] rsp, e;
   wire [15:0] pos_pin_a_i, pos_pin_b_i;
   wire [7:0] ref_pin_i, int_ref_i;
   wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   wire irq_o, wake_o, cmp_power_down_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o, result_pin_o, result_pin_oe_o;
   wire [31:0] s_axi_rdata_o;
   int n_fail = 0, compares = 0, c;
   dcc_row_t rows [8] = '{'{8'hAC, 4'h1, 8'h24, 8'h26}, '{8'hAC, 4'h0, 8'h24, 8'h24},
      '{8'hAC, 4'h4, 8'h34, 8'h36}, '{8'hAC, 4'h1, 8'h34, 8'h34}, '{8'hAC, 4'h1, 8'h2C, 8'h2C},
      '{8'hAC, 4'h0, 8'h28, 8'h28}, '{8'hAD, 4'h2, 8'h24, 8'h26}, '{8'hAD, 4'h8, 8'h34, 8'h36}};
   dcc_top i_dut (.*);
   dcc_level_model i_lvl (.pat_i(pat), .pos_a_o(pos_pin_a_i), .pos_b_o(pos_pin_b_i),
      .ref_o(ref_pin_i), .iref_o(int_ref_i));
   task report_and_stop;
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task tmo(input int n);
      if (n == 50) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   task wr(input logic [7:0] i, input logic [7:0] d);
      int n;
      s_axi_awaddr_i <= {i, 2'b00};
      s_axi_wdata_i <= {24'h0, d};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) break;
      end
      rsp = s_axi_bresp_o;
      tmo(n);
   endtask
   task rd(input logic [7:0] i);
      int n;
      s_axi_araddr_i <= {i, 2'b00};
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) break;
      end
      rv = s_axi_rdata_o;
      rsp = s_axi_rresp_o;
      tmo(n);
   endtask
   initial begin
      clk_i = 0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 0;
      {idle_mode_i, power_down_i, total_power_down_i, s_axi_awaddr_i, s_axi_araddr_i} = 0;
      s_axi_wdata_i = 0;
      s_axi_wstrb_i = 4'hF;
      pat = 4'h0;
      rst_i = 1;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         pat <= rows[i].pat;
         wr(rows[i].idx, rows[i].ctl);
         repeat (8) @(posedge clk_i);
         wr(rows[i].idx, rows[i].ctl);
         rd(rows[i].idx);
         chk(rv, {24'h0, rows[i].exp});
         c = rows[i].idx[0];
         e = {rows[i].ctl[2], rows[i].exp[1] & rows[i].ctl[2]};
         chk({result_pin_oe_o[c], result_pin_o[c]}, e);
      end
      pat <= 4'h0;
      wr(`DCC_IDX_COMPARATOR_ONE_CONTROL, 8'h24);
      repeat (8) @(posedge clk_i);
      wr(`DCC_IDX_CLEAR, 8'h03);
      wr(`DCC_IDX_IRQ_CTRL, 8'h03);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      pat <= 4'h1;
      repeat (8) @(posedge clk_i);
      chk(irq_o, 1'b1);
      rd(`DCC_IDX_COMPARATOR_ONE_CONTROL);
      chk(rv, 32'h27);
      wr(`DCC_IDX_ENABLE, 8'h02);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      wr(`DCC_IDX_ENABLE, 8'h03);
      wr(`DCC_IDX_IRQ_CTRL, 8'h01);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      wr(`DCC_IDX_IRQ_CTRL, 8'h03);
      idle_mode_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({wake_o, irq_o}, 2'b11);
      idle_mode_i <= 1'b0;
      wr(`DCC_IDX_CLEAR, 8'h01);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      repeat (500) @(posedge clk_i);
      rd(`DCC_IDX_STATUS);
      chk(rv, 32'h34);
      wr(`DCC_IDX_IRQ_CTRL, 8'h00);
      wr(`DCC_IDX_COMPARATOR_TWO_CONTROL, 8'h00);
      repeat (8) @(posedge clk_i);
      rd(`DCC_IDX_COMPARATOR_TWO_CONTROL);
      chk(rv, 32'h03);
      total_power_down_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(`DCC_IDX_COMPARATOR_ONE_CONTROL);
      chk({cmp_power_down_o, rv}, 33'h1_0000_0006);
      total_power_down_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(cmp_power_down_o, 1'b0);
      wr(`DCC_IDX_POWER, 8'h20);
      repeat (2) @(posedge clk_i);
      chk(cmp_power_down_o, 1'b1);
      rd(8'hFF);
      chk({rv, rsp}, {32'h0, `DCC_RESP_SLVERR});
      wr(8'hFF, 8'h00);
      chk(rsp, `DCC_RESP_SLVERR);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(`DCC_IDX_COMPARATOR_ONE_CONTROL);
      chk(rv, 32'h02);
      wr(`DCC_IDX_COMPARATOR_ONE_CONTROL, 8'h20);
      chk(rsp, `DCC_RESP_OKAY);
      rd(`DCC_IDX_STATUS);
      chk(rv, 32'h0C);
      repeat (480) @(posedge clk_i);
      rd(`DCC_IDX_STATUS);
      chk(rv, 32'h0C);
      repeat (30) @(posedge clk_i);
      rd(`DCC_IDX_STATUS);
      chk(rv, 32'h1C);
      s_axi_wstrb_i <= 4'hE;
      wr(`DCC_IDX_COMPARATOR_ONE_CONTROL, 8'h00);
      s_axi_wstrb_i <= 4'hF;
      rd(`DCC_IDX_COMPARATOR_ONE_CONTROL);
      chk(rv, 32'h22);
      report_and_stop;
   end
endmodule // dual_comparator_control_test
